// file: core/bus_requester.sv
// bus requester: arbitration handshake, interrupt pin, bus status, reset entry
// assumes all pins synchronous to sys_clk; dmaTick enables the bus clock rate
// Contract
// [RULE1] interrupt active whenever any enabled pending source exists
// [RULE2] masked pending sources never activate the interrupt
// [RULE3] interrupt active low with style 1, active high with style 0
// [RULE4] enter reset state after ten transmit or bus clocks of low reset
// [RULE5] three-bit bus status output always driven with current operation
// [RULE6] all DMA sequencing timed by the bus clock enable
// [RULE7] style 1: request driven low when wanted, released otherwise
// [RULE8] style 0: hold request driven high when wanted, low otherwise
// [RULE9] style 1: arbiter drives grant low to offer mastership
// [RULE10] style 0: hold acknowledge high hands over bus; treated as ownership
// [RULE11] grant ack only with grant, strobe idle, size acks idle, no owner
// [RULE12] grant ack pin used only with style 1
// [RULE13] style pin tied high for big endian, low for little endian
// [RULE14] master cycles only when owned; release request after burst ends
module bus_requester
    import bus_arb_pkg::*;
#(
    parameter int NUM_SRC = 16
) (
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    // clock enables and hardware reset pin
    input  wire logic               dmaTick,
    input  wire logic               xmitTick,
    input  wire logic               busSlowerThanXmit,
    input  wire logic               resetPinN,
    // mode strap
    input  wire logic               bus_style_select,
    // interrupt sources from the controller
    input  wire logic [NUM_SRC-1:0] irqStatus,
    input  wire logic [NUM_SRC-1:0] irqMask,
    // dma engine side
    input  wire logic               dmaWant,
    input  wire logic               burstDone,
    input  wire logic               masterWrite,
    output logic                    busOwned,
    output logic                    masterCycleGo,
    output logic                    inReset,
    // host bus arbitration pins
    input  wire arb_in_type         arbIn,
    output logic                    master_request_n,
    output logic                    masterRequestOe_n,
    output logic                    holdRequest,
    output logic                    ownership_ack_n,
    output logic                    ownershipAckOe_n,
    output logic                    irqOut,
    output logic                    irqOutOe_n,
    output logic [2:0]              bus_cycle_status
);
    arb_state_type state_ff, nxt_state;
    logic          irqOut_ff, ackDrive_ff;
    logic [2:0]    status_ff, nxt_status;

    // reset entry counts the slower clock as its tick
    wire logic resetTick = busSlowerThanXmit ? dmaTick : xmitTick; // RULE4
    reset_entry_counter #(.COUNT(RESET_ENTRY_CLOCKS)) u_rst_cnt (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .resetPinN (resetPinN),
        .tick      (resetTick),
        .inReset   (inReset)
    );

    // interrupt qualification and polarity
    wire logic irqPending = |(irqStatus & irqMask);      // RULE1 RULE2
    wire logic irqLevel   = bus_style_select ? !irqPending : irqPending; // RULE3

    // grant conditions per bus style
    wire logic bigStyle  = bus_style_select;
    wire logic bgFree    = !arbIn.grantN && arbIn.addrStrobeN
                           && !arbIn.slaveSizeAck0 && !arbIn.slaveSizeAck1
                           && arbIn.ownershipAckInN;      // RULE11
    wire logic granted   = bigStyle ? bgFree : arbIn.grantAckHi; // RULE9 RULE10 RULE12
    wire logic wantBus   = (state_ff == ARB_REQ) || (state_ff == ARB_OWN);

    // next state: idle, request, own, release back to previous owner
    always_comb begin
        nxt_state  = state_ff;
        nxt_status = status_ff;
        case (state_ff)
            ARB_IDLE: begin
                nxt_status = STAT_IDLE;
                if (dmaWant) begin
                    nxt_state  = ARB_REQ;
                    nxt_status = STAT_REQUEST;
                end
            end
            ARB_REQ: begin
                if (granted) begin
                    nxt_state  = ARB_OWN;
                    nxt_status = STAT_OWNED;
                end
            end
            ARB_OWN: begin
                nxt_status = masterWrite ? STAT_MASTER : STAT_OWNED;
                if (burstDone) begin
                    nxt_state  = ARB_RELEASE; // RULE14
                    nxt_status = STAT_RELEASE;
                end
            end
            ARB_RELEASE: begin
                nxt_state  = ARB_IDLE;
                nxt_status = STAT_IDLE;
            end
            default: begin
                nxt_state  = ARB_IDLE;
                nxt_status = STAT_IDLE;
            end
        endcase
    end

    // sequencing advances only on the bus clock enable
    always_ff @(posedge sys_clk) begin
        if (sys_rst || inReset) begin
            state_ff  <= ARB_IDLE;
            status_ff <= STAT_RESET;
        end else if (dmaTick) begin // RULE6
            state_ff  <= nxt_state;
            status_ff <= nxt_status; // RULE5
        end
    end

    // pin registers; ack held while we own the bus in big style
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irqOut_ff   <= 1'b0;
            ackDrive_ff <= 1'b0;
        end else begin
            irqOut_ff   <= irqLevel;
            // follow the state step itself, so the ack never leads or trails ownership
            ackDrive_ff <= bigStyle && !inReset
                           && (dmaTick ? (nxt_state == ARB_OWN) : (state_ff == ARB_OWN)); // RULE11 RULE12
        end
    end

    // open-drain request in big style, push-pull hold in little style
    assign master_request_n  = 1'b0;
    assign masterRequestOe_n = !(bigStyle && wantBus);           // RULE7
    assign holdRequest       = !bigStyle && wantBus;             // RULE8
    assign ownership_ack_n   = 1'b0;
    assign ownershipAckOe_n  = !ackDrive_ff;
    // open-drain style leaves the line released when inactive; low style drives always
    assign irqOut            = irqOut_ff;
    assign irqOutOe_n        = bigStyle ? irqOut_ff : 1'b0;
    assign busOwned          = (state_ff == ARB_OWN);            // RULE10
    assign masterCycleGo     = busOwned && !burstDone;           // RULE14
    assign bus_cycle_status  = status_ff;

    chk_irq_masked_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE2
        !$past(sys_rst) && !$past(irqPending) |-> irqOut_ff == $past(bus_style_select))
        else $error("interrupt active without an enabled source");
    chk_irq_follows_src: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE1
        irqPending && $stable(bus_style_select) |=> irqOut_ff == !$past(bus_style_select))
        else $error("enabled pending source did not raise interrupt");
    chk_req_open_drain: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE7
        bigStyle && !wantBus |-> masterRequestOe_n && !holdRequest)
        else $error("request driven while not wanted in big style");
    chk_hold_level: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE8
        !bigStyle |-> holdRequest == wantBus && masterRequestOe_n)
        else $error("hold request does not track want in little style");
    chk_ack_conditions: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE11
        $fell(ownershipAckOe_n) |-> $past(bgFree))
        else $error("grant ack driven without all four conditions");
    chk_ack_unused_little: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE12
        !bigStyle && $past(!bigStyle) |-> ownershipAckOe_n)
        else $error("grant ack driven in little style");
    chk_own_by_tick: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE6
        !dmaTick && !inReset |=> $stable(state_ff))
        else $error("state changed without bus clock enable");
    chk_release_after_burst: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE14
        busOwned && burstDone && dmaTick && !inReset |=> !busOwned ##1 !wantBus)
        else $error("request not withdrawn after burst");
    chk_status_reset: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE5
        inReset |=> bus_cycle_status == STAT_RESET)
        else $error("status not showing reset");
endmodule // bus_requester

// file: inc/bus_arb_pkg.sv
// package for the bus requester block: states, status codes, pin carriers
// assumes one clock, sys_clk at 125 MHz, synchronous active high reset
package bus_arb_pkg;
    // reset entry delay in transmit/bus clock periods
    localparam int RESET_ENTRY_CLOCKS = 10;
    localparam int CNT_W              = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_LAST = 4'(RESET_ENTRY_CLOCKS - 1);
    localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

    // bus cycle status codes (plain encoding of our own)
    localparam logic [2:0] STAT_IDLE    = 3'h0;
    localparam logic [2:0] STAT_REQUEST = 3'h1;
    localparam logic [2:0] STAT_OWNED   = 3'h2;
    localparam logic [2:0] STAT_MASTER  = 3'h3;
    localparam logic [2:0] STAT_RELEASE = 3'h4;
    localparam logic [2:0] STAT_RESET   = 3'h7;

    // arbitration states, gray along idle-req-own-release
    typedef enum logic [1:0] {
        ARB_IDLE    = 2'h0,
        ARB_REQ     = 2'h1,
        ARB_OWN     = 2'h3,
        ARB_RELEASE = 2'h2
    } arb_state_type;

    // sampled arbitration inputs from the host bus
    typedef struct packed {
        logic grantN;
        logic grantAckHi;
        logic addrStrobeN;
        logic slaveSizeAck0;
        logic slaveSizeAck1;
        logic ownershipAckInN;
    } arb_in_type;

    // two-signal view of a two-way or open-drain pin
    typedef struct packed {
        logic outVal;
        logic outEnN;
    } pin_drive_type;
endpackage

// file: core/reset_entry_counter.sv
// counts clock-enable ticks after reset pin falls, flags reset state entry
// assumes tick is a one-cycle enable from the slower of transmit/bus clocks
module reset_entry_counter
    import bus_arb_pkg::*;
#(
    parameter int COUNT = RESET_ENTRY_CLOCKS
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // pin and tick
    input  wire logic resetPinN,
    input  wire logic tick,
    // result
    output logic      inReset
);
    logic [CNT_W-1:0] count_ff;
    logic             inReset_ff;
    wire logic        lastTick = tick && (count_ff == CNT_W'(COUNT - 1));

    // count only while the pin is low; release leaves reset at once
    always_ff @(posedge sys_clk) begin
        if (sys_rst || resetPinN) begin
            count_ff   <= CNT_ZERO;
            inReset_ff <= 1'b0;
        end else if (lastTick) begin
            inReset_ff <= 1'b1; // RULE4
        end else if (tick && !inReset_ff) begin
            count_ff <= count_ff + CNT_ONE;
        end
    end
    assign inReset = inReset_ff;

    chk_reset_needs_ticks: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE4
        $rose(inReset_ff) |-> !resetPinN && $past(tick))
        else $error("reset state entered without a counting tick");
endmodule // reset_entry_counter

// file: tb/host_arbiter_model.sv
// host arbiter model: grants the bus a set number of cycles after a request
// assumes request pins from the requester are synchronous to sys_clk
module host_arbiter_model
    import bus_arb_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // mode and grant latency chosen by the bench
    input  wire logic       bus_style_select,
    input  wire logic [3:0] grantDelay,
    // request pins of the requester
    input  wire logic       masterRequestOe_n,
    input  wire logic       holdRequest,
    // arbitration inputs back to the requester
    output arb_in_type      arbIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] waitCnt;
    logic       wantBus;
    logic       granted;

    // request seen on whichever pin the style uses
    assign wantBus = bus_style_select ? !masterRequestOe_n : holdRequest;
    assign granted = wantBus && !sys_rst && (waitCnt >= grantDelay);
    // latency counter, cleared as soon as the request drops
    always @(posedge sys_clk) begin
        if (sys_rst || !wantBus) begin
            waitCnt <= 4'h0;
        end else if (waitCnt != 4'hf) begin
            waitCnt <= waitCnt + 4'h1;
        end
    end
    // bus idle otherwise: strobe high, size acks off, no other owner
    assign arbIn.grantN          = !(bus_style_select && granted);
    assign arbIn.grantAckHi      = !bus_style_select && granted;
    assign arbIn.addrStrobeN     = 1'b1;
    assign arbIn.slaveSizeAck0   = 1'b0;
    assign arbIn.slaveSizeAck1   = 1'b0;
    assign arbIn.ownershipAckInN = 1'b1;
endmodule // host_arbiter_model

// file: tb/master_bus_request_irq_reset_tb.sv
// bench for the bus requester: interrupt table, arbitration, reset entry
// assumes host_arbiter_model answers the request pins
`define CHK(got, exp) begin checkCount++; if ((got) !== (exp)) begin nMismatch++; \
    $display("FAIL t=%0t got %h exp %h", $time, got, exp); end end
module master_bus_request_irq_reset_tb import bus_arb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic style; logic [15:0] stat; logic [15:0] mask; logic irq; logic oeN;
    } irq_row_type;
    logic sys_clk, sys_rst, dmaTick, xmitTick, busSlowerThanXmit, resetPinN;
    logic bus_style_select, dmaWant, burstDone, masterWrite, busOwned, masterCycleGo;
    logic inReset, master_request_n, masterRequestOe_n, holdRequest, ownership_ack_n;
    logic ownershipAckOe_n, irqOut, irqOutOe_n;
    logic [15:0] irqStatus, irqMask;
    logic [2:0]  bus_cycle_status;
    logic [3:0]  grantDelay;
    logic [7:0]  dPhase;
    logic [1:0]  xPhase;
    arb_in_type  arbIn;
    int nMismatch, checkCount, n;
    irq_row_type rows [6] = '{
        '{1'b1, 16'h0001, 16'h0001, 1'b0, 1'b0}, '{1'b1, 16'h0001, 16'h0002, 1'b1, 1'b1},
        '{1'b1, 16'h8000, 16'hffff, 1'b0, 1'b0}, '{1'b0, 16'h0010, 16'h0010, 1'b1, 1'b0},
        '{1'b0, 16'h0010, 16'hffef, 1'b0, 1'b0}, '{1'b0, 16'h0000, 16'hffff, 1'b0, 1'b0}};

    bus_requester #(.NUM_SRC(16)) i_dut (.sys_clk, .sys_rst, .dmaTick, .xmitTick,
        .busSlowerThanXmit, .resetPinN, .bus_style_select, .irqStatus, .irqMask, .dmaWant,
        .burstDone, .masterWrite, .busOwned, .masterCycleGo, .inReset, .arbIn,
        .master_request_n, .masterRequestOe_n, .holdRequest, .ownership_ack_n,
        .ownershipAckOe_n, .irqOut, .irqOutOe_n, .bus_cycle_status);
    host_arbiter_model i_host (.sys_clk, .sys_rst, .bus_style_select, .grantDelay,
        .masterRequestOe_n, .holdRequest, .arbIn);

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = !sys_clk;
    end
    // bus tick every 2nd cycle, transmit tick every 3rd, so they coincide every 6th cycle
    always @(posedge sys_clk) begin
        dPhase <= dPhase + 8'h01;
        dmaTick <= dPhase[0];
        xPhase <= (xPhase == 2'h2) ? 2'h0 : xPhase + 2'h1;
        xmitTick <= (xPhase == 2'h0);
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // bounded wait for ownership to reach the wanted level
    task automatic wait_owned(input logic lvl);
        n = 0;
        do begin @(posedge sys_clk); #1; n++; end while (busOwned !== lvl && n < 100);
    endtask

    task automatic arb_run(input logic style, input logic [3:0] dly);
        @(posedge sys_clk);
        bus_style_select <= style;
        grantDelay <= dly;
        dmaWant <= 1'b1;
        masterWrite <= dly[3];
        if (dly > 4'h6) begin
            repeat (5) @(posedge sys_clk);
            #1 `CHK(bus_cycle_status, STAT_REQUEST);
        end
        wait_owned(1'b1);
        `CHK(bus_cycle_status, STAT_OWNED);
        `CHK(masterCycleGo, 1'b1);
        `CHK(masterRequestOe_n, !style);
        `CHK(holdRequest, !style);
        `CHK(ownershipAckOe_n, !style);
        // one bus tick passes, so the status shows the write cycle kind
        repeat (2) @(posedge sys_clk);
        #1 `CHK(bus_cycle_status, dly[3] ? STAT_MASTER : STAT_OWNED);
        @(posedge sys_clk);
        dmaWant <= 1'b0;
        burstDone <= 1'b1;
        #1 `CHK(masterCycleGo, 1'b0);
        wait_owned(1'b0);
        `CHK(bus_cycle_status, STAT_RELEASE);
        `CHK(masterRequestOe_n, 1'b1);
        `CHK(holdRequest, 1'b0);
        `CHK(ownershipAckOe_n, 1'b1);
        burstDone <= 1'b0;
        masterWrite <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask

    initial begin
        {sys_rst, resetPinN, dPhase, xPhase} = {2'b11, 8'h00, 2'h0};
        {dmaTick, xmitTick, busSlowerThanXmit, bus_style_select} = 4'h0;
        {dmaWant, burstDone, masterWrite, irqStatus, irqMask, grantDelay} = '0;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1 `CHK(ownershipAckOe_n, 1'b1);
        foreach (rows[i]) begin
            @(posedge sys_clk);
            {bus_style_select, irqStatus, irqMask} <= {rows[i].style, rows[i].stat, rows[i].mask};
            repeat (3) @(posedge sys_clk);
            #1 `CHK(irqOut, rows[i].irq);
            `CHK(irqOutOe_n, rows[i].oeN);
        end
        for (int s = 0; s < 4; s++) arb_run(s[0], (s < 2) ? 4'h1 : 4'h9);
        for (int s = 0; s < 2; s++) begin
            @(posedge sys_clk);
            busSlowerThanXmit <= s[0];
            resetPinN <= 1'b0;
            n = 0;
            do begin
                @(posedge sys_clk);
                if (s[0] ? dmaTick : xmitTick) n++;
                #1;
            end while (inReset !== 1'b1 && n < 40);
            `CHK(n, 10);
            @(posedge sys_clk);
            #1 `CHK(bus_cycle_status, STAT_RESET);
            resetPinN <= 1'b1;
            repeat (8) @(posedge sys_clk);
        end
        final_report();
    end

    // watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        nMismatch++;
        final_report();
    end
endmodule // master_bus_request_irq_reset_tb
